/* File: blit_engine_setup.sv */
// Summary of operation
// R1: Busy shows on configuration bit 0 and control bit 31.
// R2: Host leaves engine registers alone until the engine is idle.
// R3: Configuration value 00h means 8 bits per pixel, normal operation.
// R4: Control bits 22-20 pick the pattern row for the top destination line.
// R5: Control bit 19 clear takes real pattern data from the frame buffer.
// R6: Bits 18 and 17 clear treat the pattern as colour data.
// R7: Bit 18 set makes a monochrome pattern, expanded with foreground/background.
// R8: Bits 16-13 clear mean no masking; every destination pixel is written.
// R9: Bit 12 clear makes the mono source control register irrelevant.
// R10: Bits 10-8 matter only when the operation uses source data.
// R11: Bits 7-0 are the raster operation; F0h copies the pattern.
// R12: Without source in the operation, no source fetch and no host wait.
// R13: Pitch bits 28-16 give the destination line to line byte distance.
// R14: Source pitch bits 12-0 are ignored when no source is used.
// R15: Pattern base bits 22-3 give a quadword aligned pattern address.
// R16: Destination base bits 22-0 address the first destination byte.
// R17: Extent holds height in bits 28-16 and width in bytes 12-0.
// R18: Writing a non-zero height to the extent starts the operation; the code also needs a non-zero width and an idle engine.
// R19: Host writes the triggering height last.
// R20: The 8x8 pattern tiles across the whole destination rectangle.
// R21: Host source data arrives by writes to the data port.
// R22: Monochrome source is colour expanded before combining.
// R23: Source masking writes only pixels whose mono source bit is set.
// R24: Busy rises on trigger and falls after the last destination write.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module blit_engine_setup (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Host register port
  input wire blit_pkg::host_req_type i_host,
  output logic [31:0] o_rd_data,
  // Frame buffer port
  output blit_pkg::fb_req_type o_fb,
  input wire logic i_fb_ack,
  input wire logic [7:0] i_fb_rdata,
  // Status
  output logic o_busy
);
  import blit_pkg::*;

  // Software visible registers
  logic [7:0] cfg_r;
  logic [31:0] ctl_r;
  logic [31:0] pitch_r;
  logic [31:0] pbg_r;
  logic [31:0] pfg_r;
  logic [31:0] msc_r;
  logic [31:0] pat_r;
  logic [31:0] src_r;
  logic [31:0] dst_r;
  logic [31:0] ext_r;
  logic [31:0] sbg_r;
  logic [31:0] sfg_r;
  logic [31:0] rd_data_r;

  // Host data port
  logic [31:0] word_r;
  logic [4:0] pos_r;
  logic full_r;

  // Engine state
  state_type state_r;
  state_type state_nxt;
  fb_req_type fb_r;
  logic busy_r;
  logic [FLD_LO_HI:0] x_r;
  logic [FLD_LO_HI:0] line_r;
  logic [ADR_HI:0] dline_r;
  logic [ADR_HI:0] sline_r;
  logic [2:0] prow_r;
  logic [7:0] pat_val_r;
  logic [7:0] src_val_r;
  logic src_bit_r;
  logic [7:0] dst_val_r;

  // Decoded fields
  logic [7:0] rop;
  logic [FLD_LO_HI:0] height;
  logic [FLD_LO_HI:0] width;
  logic [FLD_LO_HI:0] dpitch;
  logic [FLD_LO_HI:0] spitch;
  logic solid;
  logic pmono;
  logic smono;
  logic shost;
  logic mask_en;
  logic need_p;
  logic need_s;
  logic need_d;
  logic start;
  logic data_wr;
  logic take;
  logic last_pos;
  logic host_bit;
  logic [7:0] host_byte;
  logic x_last;
  logic y_last;
  logic masked;
  logic [7:0] pat_use;
  logic [7:0] wr_val;
  logic [7:0] sfg;
  logic [7:0] sbg;
  logic [ADR_HI:0] pat_base;
  logic [ADR_HI:0] pat_addr;
  logic [ADR_HI:0] src_addr;

  // Evaluate raster code bitwise, index is pattern/source/destination
  function automatic logic [7:0] rop_apply(input logic [7:0] code, input logic [7:0] p,
                                           input logic [7:0] s, input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = code[{p[i], s[i], d[i]}];
    end
    return r;
  endfunction

  // Control and extent field views
  assign rop = ctl_r[7:0]; // R11
  assign solid = ctl_r[CTL_SOLID]; // R5
  assign pmono = ctl_r[CTL_PMONO]; // R6 R7
  assign smono = ctl_r[CTL_SMONO];
  assign shost = ctl_r[CTL_SHOST];
  assign mask_en = ctl_r[CTL_MASK_SRC] & smono; // R8 R23
  assign height = ext_r[FLD_HI:FLD_HI_LO]; // R17
  assign width = ext_r[FLD_LO_HI:0]; // R17
  assign dpitch = pitch_r[FLD_HI:FLD_HI_LO]; // R13
  assign spitch = pitch_r[FLD_LO_HI:0];

  // Which operands to fetch: those the raster code depends on, plus source when masking, minus a solid pattern
  assign need_p = (((rop >> 4) ^ rop) & ROP_P_MASK) != 8'h00 && !solid;
  assign need_s = ((((rop >> 2) ^ rop) & ROP_S_MASK) != 8'h00) || mask_en; // R12
  assign need_d = (((rop >> 1) ^ rop) & ROP_D_MASK) != 8'h00;

  // Trigger on a non-zero height and width written while idle
  assign start = i_host.wr && i_host.addr == OFS_EXT && !busy_r &&
                 i_host.wdata[FLD_HI:FLD_HI_LO] != '0 &&
                 i_host.wdata[FLD_LO_HI:0] != '0; // R18
  assign data_wr = i_host.wr && i_host.addr == OFS_DATA; // R21

  // Host data port bit and byte selection, msb of each byte first
  assign host_bit = word_r[{pos_r[4:3], ~pos_r[2:0]}];
  assign host_byte = word_r[{pos_r[1:0], 3'b000} +: 8];
  assign last_pos = smono ? (pos_r == 5'h1F) : (pos_r[1:0] == 2'h3);
  assign take = state_r == ST_SRC && shost && full_r; // R21

  // Source expansion colour set, chosen only for a mono source
  assign sfg = (smono && msc_r[MSC_SRC_CLR]) ? sfg_r[7:0] : pfg_r[7:0]; // R9
  assign sbg = (smono && msc_r[MSC_SRC_CLR]) ? sbg_r[7:0] : pbg_r[7:0]; // R9

  // Pattern address, tiled by row, and by column for a colour pattern only
  assign pat_base = {pat_r[ADR_HI:PAT_ADR_LO], 3'b000}; // R15
  assign pat_addr = pmono ? (pat_base | {20'h00000, prow_r})
                          : (pat_base | {17'h00000, prow_r, x_r[2:0]}); // R20

  // Source address in the frame buffer
  assign src_addr = smono ? sline_r + {13'h0000, x_r[FLD_LO_HI:3]}
                          : sline_r + {10'h000, x_r}; // R10

  // Pixel combine and mask
  assign pat_use = solid ? pfg_r[7:0] : pat_val_r;
  assign wr_val = rop_apply(rop, pat_use, src_val_r, dst_val_r); // R11
  assign masked = mask_en && !src_bit_r; // R23
  assign x_last = x_r + 13'h0001 == width;
  assign y_last = line_r + 13'h0001 == height;

  // First needed phase of a pixel
  always_comb begin
    if (need_p) begin
      state_nxt = ST_PAT;
    end else if (need_s) begin
      state_nxt = ST_SRC;
    end else if (need_d) begin
      state_nxt = ST_DST;
    end else begin
      state_nxt = ST_WR;
    end
  end

  // Register file writes
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      cfg_r <= CFG_RST; // R3
      ctl_r <= WORD_RST;
      pitch_r <= WORD_RST;
      pbg_r <= WORD_RST;
      pfg_r <= WORD_RST;
      msc_r <= WORD_RST;
      pat_r <= WORD_RST;
      src_r <= WORD_RST;
      dst_r <= WORD_RST;
      ext_r <= WORD_RST;
      sbg_r <= WORD_RST;
      sfg_r <= WORD_RST;
    end else if (i_host.wr) begin
      unique case (i_host.addr)
        OFS_CFG: cfg_r <= i_host.wdata[7:0];
        OFS_CTL: ctl_r <= {9'h000, i_host.wdata[CTL_STORE_HI:0]};
        OFS_PITCH: pitch_r <= i_host.wdata;
        OFS_PBG: pbg_r <= i_host.wdata;
        OFS_PFG: pfg_r <= i_host.wdata;
        OFS_MSC: msc_r <= i_host.wdata;
        OFS_PAT: pat_r <= i_host.wdata;
        OFS_SRC: src_r <= i_host.wdata;
        OFS_DST: dst_r <= i_host.wdata;
        OFS_EXT: ext_r <= i_host.wdata;
        OFS_SBG: sbg_r <= i_host.wdata;
        OFS_SFG: sfg_r <= i_host.wdata;
        default: ;
      endcase
    end
  end

  // Register reads, data valid in the following cycle only
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rd_data_r <= WORD_RST;
    end else if (i_host.rd) begin
      unique case (i_host.addr)
        OFS_CFG: rd_data_r <= {24'h000000, cfg_r[7:1], busy_r}; // R1
        OFS_CTL: rd_data_r <= {busy_r, full_r, ctl_r[29:0]}; // R1
        OFS_PITCH: rd_data_r <= pitch_r;
        OFS_PBG: rd_data_r <= pbg_r;
        OFS_PFG: rd_data_r <= pfg_r;
        OFS_MSC: rd_data_r <= msc_r;
        OFS_PAT: rd_data_r <= pat_r;
        OFS_SRC: rd_data_r <= src_r;
        OFS_DST: rd_data_r <= dst_r;
        OFS_EXT: rd_data_r <= ext_r;
        OFS_SBG: rd_data_r <= sbg_r;
        OFS_SFG: rd_data_r <= sfg_r;
        default: rd_data_r <= WORD_RST;
      endcase
    end else begin
      rd_data_r <= WORD_RST;
    end
  end

  // Host data port holding word; a new word wins over the final take
  // A new operation drops bits left over from the previous one
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      word_r <= WORD_RST;
      pos_r <= 5'h00;
      full_r <= 1'b0;
    end else if (start) begin
      pos_r <= 5'h00;
      full_r <= 1'b0;
    end else if (data_wr && (!full_r || (take && last_pos))) begin
      word_r <= i_host.wdata; // R21
      pos_r <= 5'h00;
      full_r <= 1'b1;
    end else if (take) begin
      pos_r <= pos_r + 5'h01;
      if (last_pos) begin
        full_r <= 1'b0;
      end
    end
  end

  // Busy flag
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      busy_r <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1; // R24
    end else if (state_r == ST_WR && x_last && y_last && (masked || i_fb_ack)) begin
      busy_r <= 1'b0; // R24
    end
  end

  // Engine sequencer and frame buffer requests
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_r <= ST_IDLE;
      fb_r <= '0;
      x_r <= '0;
      line_r <= '0;
      dline_r <= '0;
      sline_r <= '0;
      prow_r <= 3'h0;
      pat_val_r <= 8'h00;
      src_val_r <= 8'h00;
      src_bit_r <= 1'b0;
      dst_val_r <= 8'h00;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            x_r <= '0;
            line_r <= '0;
            dline_r <= dst_r[ADR_HI:0]; // R16
            sline_r <= src_r[ADR_HI:0];
            prow_r <= ctl_r[CTL_PROW_HI:CTL_PROW_LO]; // R4
            state_r <= state_nxt;
          end
        end
        ST_PAT: begin
          if (!fb_r.req) begin
            fb_r <= '{req: 1'b1, we: 1'b0, addr: pat_addr, data: 8'h00}; // R5
          end else if (i_fb_ack) begin
            fb_r.req <= 1'b0;
            if (pmono) begin
              pat_val_r <= i_fb_rdata[~x_r[2:0]] ? pfg_r[7:0] : pbg_r[7:0]; // R7
            end else begin
              pat_val_r <= i_fb_rdata; // R6
            end
            state_r <= need_s ? ST_SRC : (need_d ? ST_DST : ST_WR);
          end
        end
        ST_SRC: begin
          if (shost) begin
            if (full_r) begin
              src_bit_r <= host_bit;
              src_val_r <= smono ? (host_bit ? sfg : sbg) : host_byte; // R22
              state_r <= need_d ? ST_DST : ST_WR;
            end
          end else if (!fb_r.req) begin
            fb_r <= '{req: 1'b1, we: 1'b0, addr: src_addr, data: 8'h00};
          end else if (i_fb_ack) begin
            fb_r.req <= 1'b0;
            src_bit_r <= i_fb_rdata[~x_r[2:0]];
            if (smono) begin
              src_val_r <= i_fb_rdata[~x_r[2:0]] ? sfg : sbg; // R22
            end else begin
              src_val_r <= i_fb_rdata;
            end
            state_r <= need_d ? ST_DST : ST_WR;
          end
        end
        ST_DST: begin
          if (!fb_r.req) begin
            fb_r <= '{req: 1'b1, we: 1'b0, addr: dline_r + {10'h000, x_r}, data: 8'h00};
          end else if (i_fb_ack) begin
            fb_r.req <= 1'b0;
            dst_val_r <= i_fb_rdata;
            state_r <= ST_WR;
          end
        end
        ST_WR: begin
          if (!masked && !fb_r.req) begin
            fb_r <= '{req: 1'b1, we: 1'b1, addr: dline_r + {10'h000, x_r}, data: wr_val}; // R8
          end else if (masked || i_fb_ack) begin
            fb_r.req <= 1'b0;
            fb_r.we <= 1'b0;
            if (!x_last) begin
              x_r <= x_r + 13'h0001;
              state_r <= state_nxt;
            end else if (!y_last) begin
              x_r <= '0;
              line_r <= line_r + 13'h0001;
              dline_r <= dline_r + {10'h000, dpitch}; // R13
              sline_r <= sline_r + {10'h000, spitch}; // R14
              prow_r <= prow_r + 3'h1; // R20
              state_r <= state_nxt;
            end else begin
              state_r <= ST_IDLE; // R24
            end
          end
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign o_rd_data = rd_data_r;
  assign o_fb = fb_r;
  assign o_busy = busy_r;

endmodule

`default_nettype wire

/* File: blit_pkg.sv */
package blit_pkg;

  // Register byte offsets on the host port
  localparam int REG_AW = 8;
  localparam logic [7:0] OFS_PITCH = 8'h00;
  localparam logic [7:0] OFS_PBG = 8'h04;
  localparam logic [7:0] OFS_PFG = 8'h08;
  localparam logic [7:0] OFS_MSC = 8'h0C;
  localparam logic [7:0] OFS_CTL = 8'h10;
  localparam logic [7:0] OFS_PAT = 8'h14;
  localparam logic [7:0] OFS_SRC = 8'h18;
  localparam logic [7:0] OFS_DST = 8'h1C;
  localparam logic [7:0] OFS_EXT = 8'h20;
  localparam logic [7:0] OFS_SBG = 8'h24;
  localparam logic [7:0] OFS_SFG = 8'h28;
  localparam logic [7:0] OFS_CFG = 8'h40;
  localparam logic [7:0] OFS_DATA = 8'h80;

  // Field positions
  localparam int CFG_BUSY = 0;
  localparam int CTL_BUSY = 31;
  localparam int CTL_FULL = 30;
  localparam int CTL_PROW_HI = 22;
  localparam int CTL_PROW_LO = 20;
  localparam int CTL_SOLID = 19;
  localparam int CTL_PMONO = 18;
  localparam int CTL_MASK_SRC = 13;
  localparam int CTL_SMONO = 12;
  localparam int CTL_SHOST = 10;
  localparam int CTL_STORE_HI = 22;
  localparam int MSC_SRC_CLR = 27;
  localparam int FLD_HI = 28;
  localparam int FLD_LO_HI = 12;
  localparam int FLD_HI_LO = 16;
  localparam int ADR_HI = 22;
  localparam int PAT_ADR_LO = 3;

  // Raster operation operand masks
  localparam logic [7:0] ROP_P_MASK = 8'h0F;
  localparam logic [7:0] ROP_S_MASK = 8'h33;
  localparam logic [7:0] ROP_D_MASK = 8'h55;

  // Reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Host register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [REG_AW-1:0] addr;
    logic [31:0] wdata;
  } host_req_type;

  // Frame buffer byte request
  typedef struct packed {
    logic req;
    logic we;
    logic [ADR_HI:0] addr;
    logic [7:0] data;
  } fb_req_type;

  // Engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PAT = 5'b00010,
    ST_SRC = 5'b00100,
    ST_DST = 5'b01000,
    ST_WR = 5'b10000
  } state_type;

endpackage

/* File: blit_engine_setup_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module blit_engine_setup_checker (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Host port
  input wire blit_pkg::host_req_type i_host,
  input wire logic [31:0] o_rd_data,
  // Frame buffer and status
  input wire blit_pkg::fb_req_type o_fb,
  input wire logic i_fb_ack,
  input wire logic [7:0] i_fb_rdata,
  input wire logic o_busy
);
  import blit_pkg::*;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  // Extent write that must start an operation
  sequence s_start;
    i_host.wr && i_host.addr == OFS_EXT && !o_busy &&
      i_host.wdata[28:16] != 13'h0000 && i_host.wdata[12:0] != 13'h0000;
  endsequence
  // Status read while busy is steady
  sequence s_rd_cfg;
    i_host.rd && i_host.addr == OFS_CFG ##1 $stable(o_busy);
  endsequence
  sequence s_rd_ctl;
    i_host.rd && i_host.addr == OFS_CTL ##1 $stable(o_busy);
  endsequence
  property p_rd_idle;
    !i_host.rd |=> o_rd_data == 32'h0000_0000;
  endproperty
  property p_cfg_busy;
    s_rd_cfg |-> o_rd_data[CFG_BUSY] == o_busy;
  endproperty
  property p_ctl_busy;
    s_rd_ctl |-> o_rd_data[CTL_BUSY] == o_busy;
  endproperty
  property p_start;
    s_start |=> o_busy;
  endproperty
  property p_no_start;
    i_host.wr && i_host.addr == OFS_EXT && i_host.wdata[28:16] == 13'h0000 && !o_busy
      |=> !o_busy;
  endproperty
  property p_hold;
    o_fb.req && !i_fb_ack |=> o_fb.req && $stable(o_fb);
  endproperty
  property p_drop;
    o_fb.req && i_fb_ack |=> !o_fb.req;
  endproperty
  property p_req_busy;
    o_fb.req |-> o_busy;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
  a_cfg_busy: assert property (p_cfg_busy) else $error("configuration busy bit wrong");
  a_ctl_busy: assert property (p_ctl_busy) else $error("control busy bit wrong");
  a_start: assert property (p_start) else $error("extent write did not start");
  a_no_start: assert property (p_no_start) else $error("zero height started");
  a_hold: assert property (p_hold) else $error("frame buffer request changed early");
  a_drop: assert property (p_drop) else $error("frame buffer request not dropped");
  a_req_busy: assert property (p_req_busy) else $error("request while idle");
endmodule
bind blit_engine_setup blit_engine_setup_checker chk (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
  .i_host(i_host), .o_rd_data(o_rd_data), .o_fb(o_fb), .i_fb_ack(i_fb_ack),
  .i_fb_rdata(i_fb_rdata), .o_busy(o_busy));
`default_nettype wire

/* File: blit_fb_model.sv */
`timescale 1ns/1ps
`default_nettype none
module blit_fb_model (
  // Clock and stall control
  input wire logic i_sys_clk,
  input wire logic i_slow,
  // Frame buffer port
  input wire blit_pkg::fb_req_type i_fb,
  output logic o_ack,
  output logic [7:0] o_rdata
);
  import blit_pkg::*;
  logic [7:0] mem [int];
  int wait_r;
  int reads;
  int writes;
  // Unwritten bytes read as their low address
  function automatic logic [7:0] peek(input int a);
    return mem.exists(a) ? mem[a] : 8'(a);
  endfunction
  initial begin
    o_ack = 1'b0;
    o_rdata = 8'h00;
    wait_r = 0;
    reads = 0;
    writes = 0;
  end
  // One answer per request, optionally after a stall
  always @(posedge i_sys_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_fb.req && !o_ack) begin
      if (i_slow && wait_r < 3) begin
        wait_r <= wait_r + 1;
      end else begin
        wait_r <= 0;
        o_ack <= 1'b1;
        if (i_fb.we) begin
          mem[int'(i_fb.addr)] = i_fb.data;
          writes <= writes + 1;
        end else begin
          o_rdata <= mem.exists(int'(i_fb.addr)) ? mem[int'(i_fb.addr)] : i_fb.addr[7:0];
          reads <= reads + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: blit_engine_setup_test.sv */
`timescale 1ns/1ps
`default_nettype none
module blit_engine_setup_test;
  import blit_pkg::*;
  logic clk;
  logic rst_n;
  logic slow;
  host_req_type host;
  logic [31:0] rd_data;
  fb_req_type fb;
  logic ack;
  logic [7:0] fb_rdata;
  logic busy;
  logic [31:0] v;
  logic [31:0] word;
  int bad_count;
  int comparisons;
  int r0;
  int w0;
  blit_engine_setup dut (.i_sys_clk(clk), .i_resetn(rst_n), .i_host(host), .o_rd_data(rd_data),
    .o_fb(fb), .i_fb_ack(ack), .i_fb_rdata(fb_rdata), .o_busy(busy));
  blit_fb_model fbm (.i_sys_clk(clk), .i_slow(slow), .i_fb(fb), .o_ack(ack), .o_rdata(fb_rdata));
  // Clock
  always #10 clk = ~clk;
  // Bus cycles and comparison
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    host <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    host.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    host <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk);
    host.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      rd(OFS_CFG, v);
      if (v[CFG_BUSY] === 1'b0) return;
    end
    check("idle wait", 32'h0000_0000, 32'h0000_0001);
    conclude();
  endtask
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    slow = 1'b0;
    host = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CFG, v);
    check("configuration", 32'h0000_0000, v);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, v);
    check("unmapped", 32'h0000_0000, v);
    wr(OFS_CFG, 32'h0000_0000);
    wr(OFS_PITCH, 32'h0010_1ABC);
    wr(OFS_PAT, 32'h0010_0005);
    wr(OFS_DST, 32'h0002_0080);
    wr(OFS_MSC, 32'hFFFF_FFFF);
    wr(OFS_CTL, 32'h0030_07F0);
    rd(OFS_PITCH, v);
    check("pitch", 32'h0010_1ABC, v);
    rd(OFS_PAT, v);
    check("pattern base", 32'h0010_0000, v & 32'h007F_FFF8);
    wr(OFS_EXT, 32'h0000_000A);
    rd(OFS_CTL, v);
    check("zero height busy", 32'h0000_0000, {31'h0, v[CTL_BUSY]});
    r0 = fbm.reads;
    wr(OFS_EXT, 32'h000A_000A);
    rd(OFS_CTL, v);
    check("busy", 32'h0000_0001, {31'h0, v[CTL_BUSY]});
    check("busy pin start", 32'h0000_0001, {31'h0, busy});
    wait_idle();
    check("busy pin idle", 32'h0000_0000, {31'h0, busy});
    check("reads", 32'd100, fbm.reads - r0);
    check("writes", 32'd100, fbm.writes);
    for (int y = 0; y < 10; y++) begin
      for (int x = 0; x < 10; x++) begin
        check("fill", {26'h0, 3'((y + 3) & 7), 3'(x)}, fbm.peek(32'h20080 + y * 16 + x));
      end
    end
    // Host mono source through the data port, masked, stalling memory
    slow <= 1'b1;
    word = 32'h0000_81C3;
    wr(OFS_PFG, 32'h0000_005A);
    wr(OFS_MSC, 32'h0000_0000);
    wr(OFS_DST, 32'h0030_0000);
    wr(OFS_CTL, 32'h0000_34CC);
    r0 = fbm.reads;
    w0 = fbm.writes;
    wr(OFS_EXT, 32'h0002_0008);
    wr(OFS_DATA, word);
    wait_idle();
    check("mono reads", 32'd0, fbm.reads - r0);
    check("mono writes", 32'd6, fbm.writes - w0);
    for (int p = 0; p < 16; p++) begin
      v = {24'h0, word[(p / 8) * 8 + 7 - p % 8] ? 8'h5A : 8'((p / 8) * 16 + p % 8)};
      check("mono", v, {24'h0, fbm.peek(32'h300000 + (p / 8) * 16 + p % 8)});
    end
    // Monochrome pattern expanded with foreground and background
    wr(OFS_PBG, 32'h0000_00A5);
    wr(OFS_DST, 32'h0040_0000);
    wr(OFS_CTL, 32'h0044_00F0);
    r0 = fbm.reads;
    w0 = fbm.writes;
    wr(OFS_EXT, 32'h0002_0008);
    wait_idle();
    check("mono pattern reads", 32'd16, fbm.reads - r0);
    check("mono pattern writes", 32'd16, fbm.writes - w0);
    for (int p = 0; p < 16; p++) begin
      v = {24'h0, ((((p / 8) + 4) >> (7 - p % 8)) & 1) != 0 ? 8'h5A : 8'hA5};
      check("mono pattern", v, {24'h0, fbm.peek(32'h400000 + (p / 8) * 16 + p % 8)});
    end
    // Colour source copied from the frame buffer with its own pitch
    wr(OFS_PITCH, 32'h0010_0020);
    wr(OFS_SRC, 32'h0050_0000);
    wr(OFS_DST, 32'h0060_0000);
    wr(OFS_CTL, 32'h0000_00CC);
    r0 = fbm.reads;
    w0 = fbm.writes;
    wr(OFS_EXT, 32'h0002_0004);
    wait_idle();
    check("source reads", 32'd8, fbm.reads - r0);
    check("source writes", 32'd8, fbm.writes - w0);
    for (int p = 0; p < 8; p++) begin
      v = 32'((p / 4) * 32 + p % 4);
      check("source copy", v, {24'h0, fbm.peek(32'h600000 + (p / 4) * 16 + p % 4)});
    end
    conclude();
  end
endmodule
`default_nettype wire
